/* rtl/mcr_pkg.sv */
// constants and types shared by the monitor configuration and result register bank
package mcr_pkg;

	// bus geometry: each six-byte group takes two aligned words
	localparam int unsigned  MCR_ADDR_W      = 32;
	localparam int unsigned  MCR_DATA_W      = 32;
	localparam logic [31:0]  MCR_GROUP_STRIDE = 32'h0000_0008;
	localparam logic [31:0]  MCR_OFF_STATUS  = 32'h0000_0050;
	localparam logic [3:0]   MCR_NUM_GROUPS  = 4'ha;

	// group numbers, offset = group * stride + word * 4
	localparam logic [3:0]   MCR_GRP_CFG_A   = 4'h0;
	localparam logic [3:0]   MCR_GRP_CFG_B   = 4'h1;
	localparam logic [3:0]   MCR_GRP_CELL_A  = 4'h2;
	localparam logic [3:0]   MCR_GRP_AUX_B   = 4'h9;

	// result code slots: cells 1..18 in slots 0..17, then inputs 1..5 and second reference
	localparam int unsigned  MCR_NUM_SLOTS   = 24;
	localparam int unsigned  MCR_SLOT_W      = 5;
	localparam int unsigned  MCR_CODE_W      = 16;
	localparam logic [4:0]   MCR_SLOTS_PER_GRP = 5'h03;
	localparam logic [4:0]   MCR_SLOT_LAST   = 5'h17;
	// overlap results land in the slots that normally hold cells 8 and 14
	localparam logic [4:0]   MCR_SLOT_OVL_C1 = 5'h07;
	localparam logic [4:0]   MCR_SLOT_OVL_C2 = 5'h0d;

	// configuration group a bit positions within its 48 bits (byte k at bits 8k+7:8k)
	localparam int unsigned  MCR_A_CONV_OPT  = 0;
	localparam int unsigned  MCR_A_TMR_EN    = 1;
	localparam int unsigned  MCR_A_REF_ON    = 2;
	localparam int unsigned  MCR_A_GPI_LO    = 3;
	localparam int unsigned  MCR_A_UV_LO     = 8;
	localparam int unsigned  MCR_A_OV_LO     = 20;
	localparam int unsigned  MCR_A_DIS_LO    = 32;
	localparam int unsigned  MCR_A_TMO_LO    = 44;

	// configuration group b bit positions
	localparam int unsigned  MCR_B_GPI_LO    = 0;
	localparam int unsigned  MCR_B_DIS13_LO  = 4;
	localparam int unsigned  MCR_B_DIS17_LO  = 8;
	localparam int unsigned  MCR_B_DIS0      = 10;
	localparam int unsigned  MCR_B_MON_EN    = 11;
	localparam int unsigned  MCR_B_PATH_LO   = 12;
	localparam int unsigned  MCR_B_FRF       = 14;
	localparam int unsigned  MCR_B_MUTE      = 15;
	localparam logic [47:0]  MCR_B_USED_MASK = 48'h0000_0000_ffff;

	// reset values
	localparam logic [47:0]  MCR_CFG_RST     = 48'h0000_0000_0000;
	localparam logic [15:0]  MCR_CODE_RST    = 16'h0000;
	localparam logic [31:0]  MCR_WORD_ZERO   = 32'h0000_0000;

	// status word: overlap markers and per-result-group fresh flags
	localparam int unsigned  MCR_ST_OVL_LO   = 0;
	localparam int unsigned  MCR_ST_FRESH_LO = 8;

	// ahb-lite encodings
	localparam logic [1:0]   MCR_HTRANS_NSEQ = 2'h2;
	localparam logic         MCR_HRESP_OKAY  = 1'b0;

	typedef enum logic [1:0] {
		MCR_BUS_IDLE    = 2'b00,
		MCR_BUS_RD_WAIT = 2'b01
	} mcr_bus_st_t;

	typedef struct packed {
		mcr_bus_st_t  st;
		logic         wr_pend;
		logic [31:0]  addr;
		logic [31:0]  rdata;
		logic         ready;
		logic         resp;
		logic [1:0]   ovl;
		logic [7:0]   fresh;
	} mcr_top_state_t;

	typedef struct packed {
		logic [1:0][47:0] grp;
	} mcr_cfg_state_t;

	typedef struct packed {
		logic [23:0][15:0] code;
	} mcr_res_state_t;

endpackage

/* rtl/mcr_cfg_store.sv */
// configuration group storage: two six-byte groups, all of group a and bytes 0..1 of group b read/write
module mcr_cfg_store
	import mcr_pkg::*;
(
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic         ce,
	// word write port
	input  wire logic         we,
	input  wire logic         grp_sel,
	input  wire logic         word_sel,
	input  wire logic [31:0]  wdata,
	// stored groups
	output logic      [47:0]  cfg_a,
	output logic      [47:0]  cfg_b
);
	import mcr_pkg::*;

	mcr_cfg_state_t q;
	mcr_cfg_state_t d;

	always_comb begin
		d = q;
		if (we) begin
			if (word_sel) begin
				d.grp[grp_sel][47:32] = wdata[15:0];
			end else begin
				d.grp[grp_sel][31:0] = wdata;
			end
		end
		// bytes 2..5 of group b hold nothing and read zero
		d.grp[1] = d.grp[1] & MCR_B_USED_MASK;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			q.grp[0] <= MCR_CFG_RST;
			q.grp[1] <= MCR_CFG_RST;
		end else if (ce) begin
			q <= d;
		end
	end

	assign cfg_a = q.grp[0];
	assign cfg_b = q.grp[1];

endmodule

/* rtl/mcr_result_store.sv */
// result code storage: cell and auxiliary conversion codes, two write ports
module mcr_result_store
	import mcr_pkg::*;
(
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic         ce,
	// normal result port
	input  wire logic         a_we,
	input  wire logic [4:0]   a_slot,
	input  wire logic [15:0]  a_data,
	// overlap result port, wins over the normal port on the same slot
	input  wire logic         b_we,
	input  wire logic [4:0]   b_slot,
	input  wire logic [15:0]  b_data,
	// stored codes, slot n at bits 16n+15:16n
	output logic [383:0]      codes
);
	import mcr_pkg::*;

	mcr_res_state_t q;
	mcr_res_state_t d;

	always_comb begin
		d = q;
		for (int i = 0; i < MCR_NUM_SLOTS; i++) begin
			if (b_we && b_slot == 5'(i)) begin
				d.code[i] = b_data;
			end else if (a_we && a_slot == 5'(i)) begin
				d.code[i] = a_data;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			for (int i = 0; i < MCR_NUM_SLOTS; i++) begin
				q.code[i] <= MCR_CODE_RST;
			end
		end else if (ce) begin
			q <= d;
		end
	end

	assign codes = q.code;

endmodule

/* rtl/mcr_reg_bank.sv */
// top of the monitor configuration and result register bank with its ahb-lite slave
//
// Local design decisions: the address map and the AHB-Lite interface to the registers.
module mcr_reg_bank
	import mcr_pkg::*;
(
	// clock, reset, enable
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic         ce,
	// ahb-lite slave
	input  wire logic         hsel,
	input  wire logic [31:0]  haddr,
	input  wire logic [1:0]   htrans,
	input  wire logic         hwrite,
	input  wire logic [2:0]   hsize,
	input  wire logic [31:0]  hwdata,
	input  wire logic         hready,
	output logic              hreadyout,
	output logic      [31:0]  hrdata,
	output logic              hresp,
	// conversion results from the measurement side
	input  wire logic         code_valid,
	input  wire logic [4:0]   code_slot,
	input  wire logic [15:0]  code_data,
	input  wire logic         overlap_valid,
	input  wire logic         overlap_conv,
	input  wire logic [15:0]  overlap_data,
	// configuration fields to the analog side
	output logic      [8:0]   gpio_pulldown,
	output logic              reference_keep_on,
	output logic              discharge_timer_enable,
	output logic              converter_option,
	output logic      [11:0]  undervoltage_threshold,
	output logic      [11:0]  overvoltage_threshold,
	output logic      [18:0]  cell_discharge_control,
	output logic      [3:0]   discharge_timeout,
	output logic              discharge_mute,
	output logic              force_redundancy_fail,
	output logic      [1:0]   path_select,
	output logic              discharge_monitor_enable,
	// status seen by the analog side as well as software
	output logic      [1:0]   overlap_marks,
	output logic      [7:0]   results_fresh
);
	import mcr_pkg::*;

	mcr_top_state_t q;
	mcr_top_state_t d;

	logic [47:0]  cfg_a;
	logic [47:0]  cfg_b;
	logic [383:0] codes;
	logic         cfg_we;
	logic         wr_hit;
	logic         rd_hit;
	logic         code_ok;
	logic [4:0]   ovl_slot;
	logic         take;

	// an address maps to a group word, or to the status word
	function automatic logic addr_hit(input logic [31:0] a);
		logic grp_ok;
		grp_ok = (a[31:7] == 25'h0) && (a[6:3] < MCR_NUM_GROUPS);
		return (a[1:0] == 2'h0) && (grp_ok || a == MCR_OFF_STATUS);
	endfunction

	function automatic logic [3:0] addr_grp(input logic [31:0] a);
		return a[6:3];
	endfunction

	// result group that holds a given slot
	function automatic logic [2:0] slot_grp(input logic [4:0] s);
		return 3'(s / MCR_SLOTS_PER_GRP);
	endfunction

	function automatic logic [15:0] code_at(input logic [383:0] c, input logic [4:0] s);
		return c[16*s +: 16];
	endfunction

	// word view of a group: bytes 0..3 in word 0, bytes 4..5 low in word 1
	function automatic logic [31:0] read_word(input logic [31:0] a,
		input logic [47:0] ca, input logic [47:0] cb, input logic [383:0] c,
		input logic [1:0] ov, input logic [7:0] fr);
		logic [47:0] g;
		logic [4:0]  base;
		logic [31:0] w;
		g = MCR_CFG_RST;
		base = 5'h0;
		w = MCR_WORD_ZERO;
		if (addr_hit(a)) begin
			if (a == MCR_OFF_STATUS) begin
				w[MCR_ST_OVL_LO +: 2] = ov;
				w[MCR_ST_FRESH_LO +: 8] = fr;
			end else begin
				if (addr_grp(a) == MCR_GRP_CFG_A) begin
					g = ca;
				end else if (addr_grp(a) == MCR_GRP_CFG_B) begin
					g = cb;
				end else begin
					// three codes per group, lowest slot first in bytes 0..1
					base = 5'(addr_grp(a) - MCR_GRP_CELL_A) * MCR_SLOTS_PER_GRP;
					g = {code_at(c, base + 5'h2), code_at(c, base + 5'h1), code_at(c, base)};
				end
				w = a[2] ? {16'h0000, g[47:32]} : g[31:0];
			end
		end
		return w;
	endfunction

	assign take = hsel && htrans == MCR_HTRANS_NSEQ && hready;
	assign wr_hit = q.wr_pend && addr_hit(q.addr);
	assign rd_hit = addr_hit(q.addr);
	// besides the status word, only the two configuration groups accept writes; results ignore them
	assign cfg_we = ce && wr_hit && q.addr != MCR_OFF_STATUS
		&& addr_grp(q.addr) <= MCR_GRP_CFG_B;
	assign code_ok = code_valid && code_slot <= MCR_SLOT_LAST;
	// overlap codes replace the cell 8 and cell 14 slots
	assign ovl_slot = overlap_conv ? MCR_SLOT_OVL_C2 : MCR_SLOT_OVL_C1;

	mcr_cfg_store u_cfg (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.ce       (ce),
		.we       (cfg_we),
		.grp_sel  (q.addr[3]),
		.word_sel (q.addr[2]),
		.wdata    (hwdata),
		.cfg_a    (cfg_a),
		.cfg_b    (cfg_b)
	);

	mcr_result_store u_res (
		.clk_sys (clk_sys),
		.rst     (rst),
		.ce      (ce),
		.a_we    (code_ok),
		.a_slot  (code_slot),
		.a_data  (code_data),
		.b_we    (overlap_valid),
		.b_slot  (ovl_slot),
		.b_data  (overlap_data),
		.codes   (codes)
	);

	always_comb begin
		d = q;
		d.resp = MCR_HRESP_OKAY;
		d.wr_pend = 1'b0;
		// status write: one clears a fresh flag, a new result in the same cycle wins
		if (wr_hit && q.addr == MCR_OFF_STATUS) begin
			d.fresh = q.fresh & ~hwdata[MCR_ST_FRESH_LO +: 8];
		end
		// every result group, auxiliary ones too, owns the flag of its group number less two (slot / 3)
		if (code_ok) begin
			d.fresh[slot_grp(code_slot)] = 1'b1;
		end
		// a normal code into an overlap slot removes its mark, an overlap code sets it
		if (code_ok && code_slot == MCR_SLOT_OVL_C1) begin
			d.ovl[0] = 1'b0;
		end
		if (code_ok && code_slot == MCR_SLOT_OVL_C2) begin
			d.ovl[1] = 1'b0;
		end
		if (overlap_valid) begin
			d.ovl[overlap_conv] = 1'b1;
			d.fresh[slot_grp(ovl_slot)] = 1'b1;
		end
		case (q.st)
			MCR_BUS_IDLE: begin
				d.ready = 1'b1;
				if (take) begin
					d.addr = haddr;
					d.wr_pend = hwrite;
					if (!hwrite) begin
						d.st = MCR_BUS_RD_WAIT;
						d.ready = 1'b0;
					end
				end
			end
			MCR_BUS_RD_WAIT: begin
				// one wait state lets a write just before the read land first
				d.rdata = rd_hit ? read_word(q.addr, cfg_a, cfg_b, codes, q.ovl, q.fresh)
					: MCR_WORD_ZERO;
				d.ready = 1'b1;
				d.st = MCR_BUS_IDLE;
			end
			default: begin
				d.st = MCR_BUS_IDLE;
				d.ready = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			q.st <= MCR_BUS_IDLE;
			q.wr_pend <= 1'b0;
			q.addr <= MCR_WORD_ZERO;
			q.rdata <= MCR_WORD_ZERO;
			q.ready <= 1'b1;
			q.resp <= MCR_HRESP_OKAY;
			q.ovl <= 2'h0;
			q.fresh <= 8'h00;
		end else if (ce) begin
			q <= d;
		end
	end

	assign hreadyout = q.ready;
	assign hrdata = q.rdata;
	assign hresp = q.resp;
	assign overlap_marks = q.ovl;
	assign results_fresh = q.fresh;

	// configuration fields, straight slices of the stored groups
	assign converter_option = cfg_a[MCR_A_CONV_OPT];
	assign discharge_timer_enable = cfg_a[MCR_A_TMR_EN];
	assign reference_keep_on = cfg_a[MCR_A_REF_ON];
	assign gpio_pulldown = {cfg_b[MCR_B_GPI_LO +: 4], cfg_a[MCR_A_GPI_LO +: 5]};
	assign undervoltage_threshold = cfg_a[MCR_A_UV_LO +: 12];
	assign overvoltage_threshold = cfg_a[MCR_A_OV_LO +: 12];
	assign discharge_timeout = cfg_a[MCR_A_TMO_LO +: 4];
	assign cell_discharge_control = {cfg_b[MCR_B_DIS17_LO +: 2], cfg_b[MCR_B_DIS13_LO +: 4],
		cfg_a[MCR_A_DIS_LO +: 12], cfg_b[MCR_B_DIS0]};
	assign discharge_monitor_enable = cfg_b[MCR_B_MON_EN];
	assign path_select = cfg_b[MCR_B_PATH_LO +: 2];
	assign force_redundancy_fail = cfg_b[MCR_B_FRF];
	assign discharge_mute = cfg_b[MCR_B_MUTE];

endmodule

/* verif/mcr_reg_bank_asserts.sv */
// port assertions for the register bank
module mcr_reg_bank_chk (
	// clock and control
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        ce,
	// bus
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic        hresp,
	// results and fields
	input wire logic        code_valid,
	input wire logic [4:0]  code_slot,
	input wire logic        overlap_valid,
	input wire logic        overlap_conv,
	input wire logic [11:0] undervoltage_threshold,
	input wire logic [18:0] cell_discharge_control,
	input wire logic [1:0]  overlap_marks,
	input wire logic [7:0]  results_fresh
);
	timeunit 1ns;
	timeprecision 1ns;
	import mcr_pkg::*;
	logic tk;
	logic wr_tk;
	logic rd_tk;
	assign tk = hsel && htrans == MCR_HTRANS_NSEQ && hready && ce;
	assign wr_tk = tk && hwrite;
	assign rd_tk = tk && !hwrite;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	chk_resp_okay: assert property (hresp == MCR_HRESP_OKAY)
		else $error("bus response not okay");
	chk_read_wait: assert property (rd_tk |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	chk_write_nowait: assert property (wr_tk |=> hreadyout)
		else $error("write stalled");
	chk_cfg_hold: assert property (!$past(wr_tk, 2)
		|-> $stable(undervoltage_threshold) && $stable(cell_discharge_control))
		else $error("config changed without write");
	chk_rdata_hold: assert property (!$past(rd_tk, 2) |-> $stable(hrdata))
		else $error("read data changed without read");
	chk_mark_conv1: assert property (overlap_valid && !overlap_conv && ce |=> overlap_marks[0])
		else $error("overlap mark one not set");
	chk_mark_conv2: assert property (overlap_valid && overlap_conv && ce |=> overlap_marks[1])
		else $error("overlap mark two not set");
	chk_mark_clear: assert property (code_valid && ce && code_slot == MCR_SLOT_OVL_C1
		&& !overlap_valid |=> !overlap_marks[0]) else $error("overlap mark not cleared");
	chk_fresh_set: assert property (code_valid && ce && code_slot < 5'h18
		|=> results_fresh[$past(code_slot) / 3]) else $error("fresh flag not set");
endmodule

bind mcr_reg_bank mcr_reg_bank_chk i_chk (.clk_sys, .rst, .ce, .hsel, .htrans, .hwrite, .hready,
	.hreadyout, .hrdata, .hresp, .code_valid, .code_slot, .overlap_valid, .overlap_conv,
	.undervoltage_threshold, .cell_discharge_control, .overlap_marks, .results_fresh);

/* verif/mcr_host_model.sv */
// ahb-lite master standing in for the host processor
module mcr_host_model (
	// clock
	input wire logic         clk_sys,
	// ahb-lite master
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata
);
	timeunit 1ns;
	timeprecision 1ns;
	import mcr_pkg::*;
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// one single word transfer, waits on hready in both phases
	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
			output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= MCR_HTRANS_NSEQ;
		hwrite <= w;
		do @(posedge clk_sys); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hready !== 1'b1);
		q = hrdata;
	endtask
endmodule

/* verif/mcr_reg_bank_tb_top.sv */
// testbench for the register bank
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module mcr_reg_bank_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import mcr_pkg::*;
	logic clk_sys, rst, ce, hsel, hwrite, hreadyout, hresp, code_valid, overlap_valid;
	logic overlap_conv, reference_keep_on, discharge_timer_enable, converter_option;
	logic discharge_mute, force_redundancy_fail, discharge_monitor_enable;
	logic [31:0] haddr, hwdata, hrdata;
	logic [15:0] code_data, overlap_data;
	logic [11:0] undervoltage_threshold, overvoltage_threshold;
	logic [18:0] cell_discharge_control;
	logic [8:0]  gpio_pulldown;
	logic [7:0]  results_fresh;
	logic [4:0]  code_slot;
	logic [3:0]  discharge_timeout;
	logic [2:0]  hsize;
	logic [1:0]  htrans, path_select, overlap_marks;
	int          mismatches = 0;
	int          compares = 0;
	int          cycles = 0;
	wire  [7:0]  cfgb1 = {discharge_mute, force_redundancy_fail, path_select,
		discharge_monitor_enable, cell_discharge_control[0], cell_discharge_control[18:17]};
	mcr_reg_bank i_dut (.clk_sys, .rst, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hrdata, .hresp, .code_valid, .code_slot, .code_data,
		.overlap_valid, .overlap_conv, .overlap_data, .gpio_pulldown, .reference_keep_on,
		.discharge_timer_enable, .converter_option, .undervoltage_threshold,
		.overvoltage_threshold, .cell_discharge_control, .discharge_timeout, .discharge_mute,
		.force_redundancy_fail, .path_select, .discharge_monitor_enable, .overlap_marks,
		.results_fresh);
	mcr_host_model i_host (.clk_sys, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata);
	function automatic logic [15:0] cf(int s);
		return 16'ha000 + 16'(s) * 16'h0111;
	endfunction
	task automatic rd(input logic [31:0] a, output logic [31:0] q);
		i_host.xfer(a, 1'b0, 32'h0, q);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] t;
		i_host.xfer(a, 1'b1, d, t);
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	initial begin
		logic [31:0] v;
		logic [31:0] w;
		int g;
		rst <= 1'b1;
		ce <= 1'b1;
		code_valid <= 1'b0;
		code_slot <= 5'h00;
		code_data <= 16'h0000;
		overlap_valid <= 1'b0;
		overlap_conv <= 1'b0;
		overlap_data <= 16'h0000;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		for (g = 0; g < 11; g++) begin
			rd(32'(g) * 32'h8, v);
			`CHK(v, 32'h0)
		end
		$display("test reset values done");
		w = 32'h9abc_def5;
		wr(32'h0, w);
		wr(32'h4, 32'hffff_c3a5);
		@(posedge clk_sys);
		`CHK({gpio_pulldown[4:0], reference_keep_on, discharge_timer_enable, converter_option}, w[7:0])
		`CHK({overvoltage_threshold, undervoltage_threshold}, w[31:8])
		`CHK({discharge_timeout, cell_discharge_control[12:1]}, 16'hc3a5)
		rd(32'h4, v);
		`CHK(v, 32'h0000_c3a5)
		wr(MCR_GROUP_STRIDE, 32'hffff_a55a);
		wr(MCR_GROUP_STRIDE + 32'h4, 32'hffff_ffff);
		@(posedge clk_sys);
		`CHK({cell_discharge_control[16:13], gpio_pulldown[8:5]}, 8'h5a)
		`CHK(cfgb1, 8'ha5)
		rd(MCR_GROUP_STRIDE, v);
		`CHK(v, 32'h0000_a55a)
		rd(MCR_GROUP_STRIDE + 32'h4, v);
		`CHK(v, 32'h0)
		$display("test config groups done");
		for (g = 0; g < 24; g++) begin
			code_valid <= 1'b1;
			code_slot <= 5'(g);
			code_data <= cf(g);
			@(posedge clk_sys);
		end
		code_valid <= 1'b0;
		for (g = 2; g < 10; g++) begin
			wr(32'(g) * 32'h8, 32'hffff_ffff);
			rd(32'(g) * 32'h8, v);
			`CHK(v, {cf(3 * g - 5), cf(3 * g - 6)})
			rd(32'(g) * 32'h8 + 32'h4, v);
			`CHK(v, {16'h0, cf(3 * g - 4)})
		end
		$display("test result groups done");
		overlap_valid <= 1'b1;
		overlap_data <= 16'h7777;
		@(posedge clk_sys);
		overlap_conv <= 1'b1;
		overlap_data <= 16'h5eed;
		@(posedge clk_sys);
		overlap_valid <= 1'b0;
		rd(32'h20, v);
		`CHK(v, {16'h7777, cf(6)})
		rd(32'h30, v);
		`CHK(v, {16'h5eed, cf(12)})
		rd(MCR_OFF_STATUS, v);
		`CHK(v, 32'h0000_ff03)
		wr(MCR_OFF_STATUS, 32'h0000_ff00);
		code_valid <= 1'b1;
		code_slot <= MCR_SLOT_OVL_C1;
		code_data <= 16'h1234;
		@(posedge clk_sys);
		code_valid <= 1'b0;
		rd(MCR_OFF_STATUS, v);
		`CHK(v, 32'h0000_0402)
		rd(32'h20, v);
		`CHK(v, {16'h1234, cf(6)})
		$display("test overlap done");
		ce <= 1'b0;
		code_valid <= 1'b1;
		code_slot <= 5'h00;
		code_data <= 16'hdead;
		@(posedge clk_sys);
		ce <= 1'b1;
		code_valid <= 1'b0;
		rd(32'h10, v);
		`CHK(v, {cf(1), cf(0)})
		rd(MCR_OFF_STATUS, v);
		`CHK(v, 32'h0000_0402)
		$display("test clock enable done");
		rd(32'h58, v);
		`CHK(v, 32'h0)
		rd(32'h2, v);
		`CHK(v, 32'h0)
		wr(32'h58, 32'hffff_ffff);
		rd(32'h0, v);
		`CHK(v, w)
		$display("test unmapped done");
		tally_and_finish();
	end
endmodule
